// file: sim/adcrd_host.sv
`timescale 1ns/1ps
module adcrd_host
	import adcrd_pkg::*;
#(
	parameter int CMD_WAIT_CYC = 20
) (
	input wire logic mclk_in,
	output logic cmd_valid_out,
	output logic [7:0] cmd_base_out,
	output logic [7:0] cmd_reg_out,
	output logic wr_valid_out,
	output logic [7:0] wr_data_out,
	output logic rd_req_out
);
	logic [7:0] exp_q[$];
	initial begin
		cmd_valid_out = 1'b0;
		cmd_base_out = 8'h00;
		cmd_reg_out = 8'h00;
		wr_valid_out = 1'b0;
		wr_data_out = 8'h00;
		rd_req_out = 1'b0;
	end
	// idle lines flip so nothing leans on a stale value
	task automatic cmd(input logic [7:0] base, input logic [7:0] rg, input bit wait_ok);
		@(posedge mclk_in);
		cmd_valid_out <= 1'b1;
		cmd_base_out <= base;
		cmd_reg_out <= rg;
		@(posedge mclk_in);
		cmd_valid_out <= 1'b0;
		cmd_base_out <= ~base;
		cmd_reg_out <= ~rg;
		if (wait_ok) repeat (CMD_WAIT_CYC) @(posedge mclk_in);
	endtask
	task automatic wr(input logic [7:0] d);
		@(posedge mclk_in);
		wr_valid_out <= 1'b1;
		wr_data_out <= d;
		@(posedge mclk_in);
		wr_valid_out <= 1'b0;
		wr_data_out <= ~d;
	endtask
	task automatic rd(input logic [7:0] exp, input bit answered);
		@(posedge mclk_in);
		rd_req_out <= 1'b1;
		if (answered) exp_q.push_back(exp);
		@(posedge mclk_in);
		rd_req_out <= 1'b0;
	endtask
endmodule // adcrd_host

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
	import adcrd_pkg::*;
	localparam int GAP_C = 40;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic cmd_valid_in, wr_valid_in, rd_req_in;
	logic [7:0] cmd_base_in, cmd_reg_in, wr_data_in, rd_data_out;
	logic sample_valid_in = 1'b0;
	logic [4:0] sample_chan_in = 5'h00;
	logic [9:0] sample_data_in = 10'h000;
	logic sample_error_in = 1'b0;
	logic rd_valid_out, irq_out, window_mode_out;
	logic [4:0] chans[4] = '{5'd0, 5'd1, 5'd3, 5'd20};
	logic [9:0] vals[4];
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	always #20 mclk_in = ~mclk_in;
	adcrd_host #(.CMD_WAIT_CYC(20)) u_host (.mclk_in, .cmd_valid_out(cmd_valid_in),
		.cmd_base_out(cmd_base_in), .cmd_reg_out(cmd_reg_in), .wr_valid_out(wr_valid_in),
		.wr_data_out(wr_data_in), .rd_req_out(rd_req_in));
	adcrd_readout #(.CHAN_MASK(ADCRD_CHAN_MASK_11), .CMD_WAIT_CYC(20), .CHAN_GAP_CYC(GAP_C))
	u_dut (.mclk_in, .rst_n_in, .cmd_valid_in, .cmd_base_in, .cmd_reg_in, .wr_valid_in,
		.wr_data_in, .rd_req_in, .sample_valid_in, .sample_chan_in, .sample_data_in,
		.sample_error_in, .rd_data_out, .rd_valid_out, .irq_out, .window_mode_out);
	task automatic close_out();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_level(input string what, input logic exp, input logic got);
		check_byte(what, {7'h00, exp}, {7'h00, got});
	endtask
	// ****************************************
	// answer watcher
	// ****************************************
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 4000) begin
			errors++;
			$display("mismatch run length expected below 4000 seen %0d", cycles);
			close_out();
		end else if (rst_n_in === 1'b1 && rd_valid_out !== 1'b0) begin
			if (u_host.exp_q.size() == 0) check_byte("unasked answer", 8'h00, 8'hFF);
			else check_byte("read byte", u_host.exp_q.pop_front(), rd_data_out);
		end
	end
	task automatic sample(input logic [4:0] ch, input logic [9:0] v, input logic err);
		@(posedge mclk_in);
		sample_valid_in <= 1'b1;
		sample_chan_in <= ch;
		sample_data_in <= v;
		sample_error_in <= err;
		@(posedge mclk_in);
		sample_valid_in <= 1'b0;
		sample_error_in <= 1'b0;
		sample_data_in <= ~v;
		repeat (2) @(posedge mclk_in);
	endtask
	task automatic read_chan(input logic [4:0] ch, input logic [9:0] v, input bit early);
		if (!early) repeat (GAP_C) @(posedge mclk_in);
		u_host.cmd(ADCRD_MODULE_BASE, ADCRD_REG_RESULT_FIRST + 8'(ch), !early);
		u_host.rd({6'h00, v[9:8]}, 1'b1);
		u_host.rd(v[7:0], 1'b1);
	endtask
	task automatic read_status(input logic [7:0] exp);
		u_host.cmd(ADCRD_MODULE_BASE, ADCRD_REG_STATUS, 1'b1);
		u_host.rd(exp, 1'b1);
		repeat (3) @(posedge mclk_in);
	endtask
	task automatic write_reg(input logic [7:0] rg, input logic [7:0] d);
		u_host.cmd(ADCRD_MODULE_BASE, rg, 1'b0);
		u_host.wr(d);
		repeat (3) @(posedge mclk_in);
	endtask
	initial begin
		void'($urandom(32'h21AC0F3C));
		repeat (2) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		@(posedge mclk_in);
		check_level("irq after reset", 1'b0, irq_out);
		check_level("window mode after reset", 1'b0, window_mode_out);
		foreach (chans[i]) begin
			vals[i] = 10'($urandom);
			sample(chans[i], vals[i], 1'b0);
		end
		foreach (chans[i]) read_chan(chans[i], vals[i], 1'b0);
		read_status(8'h00);
		read_chan(chans[1], vals[1], 1'b1);
		read_status(8'h01);
		read_status(8'h00);
		sample(5'd2, 10'h155, 1'b1);
		read_status(8'h01);
		sample(5'd4, 10'h3FF, 1'b0);
		read_chan(5'd4, ADCRD_RESULT_RESET, 1'b0);
		u_host.cmd(8'h08, ADCRD_REG_RESULT_FIRST, 1'b1);
		u_host.rd(8'h00, 1'b0);
		u_host.cmd(ADCRD_MODULE_BASE, 8'h06, 1'b1);
		u_host.rd(8'h00, 1'b1);
		write_reg(ADCRD_REG_RESULT_FIRST, 8'hFF);
		read_chan(chans[0], vals[0], 1'b0);
		// ****************************************
		// window compare and interrupt
		// ****************************************
		write_reg(ADCRD_REG_WINDOW_MODE, ADCRD_WINDOW_MODE_ON);
		check_level("window mode on", 1'b1, window_mode_out);
		u_host.cmd(ADCRD_MODULE_BASE, ADCRD_REG_WINDOW_THRESH, 1'b0);
		foreach (chans[i]) u_host.wr(8'(32'h01000080 >> (24 - 8 * i)));
		write_reg(ADCRD_REG_IRQ_ENABLE_SET, 8'h01);
		sample(5'd0, 10'h0C0, 1'b0);
		check_level("irq inside window", 1'b0, irq_out);
		sample(5'd0, 10'h200 | 10'($urandom % 256), 1'b0);
		check_level("irq above upper", 1'b1, irq_out);
		repeat (30) @(posedge mclk_in);
		check_level("irq held", 1'b1, irq_out);
		read_status(8'h02);
		check_level("irq after status read", 1'b0, irq_out);
		sample(5'd0, 10'($urandom % 128), 1'b0);
		check_level("irq below lower", 1'b1, irq_out);
		write_reg(ADCRD_REG_IRQ_ENABLE_CLEAR, 8'h01);
		check_level("irq disabled", 1'b0, irq_out);
		read_status(8'h02);
		write_reg(ADCRD_REG_WINDOW_MODE, 8'h00);
		check_level("window mode off", 1'b0, window_mode_out);
		// ****************************************
		// reset in mid-run wipes the stored results
		// ****************************************
		rst_n_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		@(posedge mclk_in);
		check_level("irq after mid-run reset", 1'b0, irq_out);
		read_chan(chans[3], ADCRD_RESULT_RESET, 1'b0);
		repeat (5) @(posedge mclk_in);
		check_byte("answers left", 8'h00, 8'(u_host.exp_q.size()));
		close_out();
	end
endmodule // tb

// file: verilog/adcrd_pkg.sv
package adcrd_pkg;
	// ****************************************
	// module addressing
	// ****************************************
	localparam logic [7:0] ADCRD_MODULE_BASE = 8'h09;
	localparam logic [7:0] ADCRD_REG_STATUS = 8'h00;
	localparam logic [7:0] ADCRD_REG_IRQ_ENABLE_SET = 8'h02;
	localparam logic [7:0] ADCRD_REG_IRQ_ENABLE_CLEAR = 8'h03;
	localparam logic [7:0] ADCRD_REG_WINDOW_MODE = 8'h04;
	localparam logic [7:0] ADCRD_REG_WINDOW_THRESH = 8'h05;
	localparam logic [7:0] ADCRD_REG_RESULT_FIRST = 8'h07;
	localparam logic [7:0] ADCRD_REG_RESULT_LAST = 8'h1B;

	// ****************************************
	// fields and widths
	// ****************************************
	localparam int ADCRD_RES_BITS = 10;
	localparam int ADCRD_RESULT_BYTES = 2;
	localparam int ADCRD_THRESH_BYTES = 4;
	localparam int ADCRD_MAX_CHAN = 20;
	localparam int ADCRD_NUM_SLOTS = ADCRD_MAX_CHAN + 1;
	localparam int ADCRD_STATUS_ERROR_BIT = 0;
	localparam int ADCRD_STATUS_WINDOW_BIT = 1;
	localparam int ADCRD_IRQ_WINDOW_BIT = 0;
	localparam logic [7:0] ADCRD_WINDOW_MODE_ON = 8'h01;
	localparam logic [20:0] ADCRD_CHAN_MASK_4 = 21'h00000F;
	localparam logic [20:0] ADCRD_CHAN_MASK_11 = 21'h1C0CCF;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [31:0] ADCRD_THRESH_RESET = 32'hFFFF0000;
	localparam logic [9:0] ADCRD_RESULT_RESET = 10'h000;

	// ****************************************
	// host timing
	// ****************************************
	localparam int ADCRD_CLK_HZ = 25000000;
	localparam int ADCRD_CMD_WAIT_US = 500;
	localparam int ADCRD_CHAN_GAP_US = 1000;
	localparam int ADCRD_CMD_WAIT_CYC = (ADCRD_CLK_HZ / 1000000) * ADCRD_CMD_WAIT_US;
	localparam int ADCRD_CHAN_GAP_CYC = (ADCRD_CLK_HZ / 1000000) * ADCRD_CHAN_GAP_US;
endpackage

// file: verilog/adcrd_readout.sv
`timescale 1ns/1ps
module adcrd_readout
	import adcrd_pkg::*;
#(
	parameter logic [20:0] CHAN_MASK = ADCRD_CHAN_MASK_4,
	parameter int CMD_WAIT_CYC = ADCRD_CMD_WAIT_CYC,
	parameter int CHAN_GAP_CYC = ADCRD_CHAN_GAP_CYC
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_base_in,
	input wire logic [7:0] cmd_reg_in,
	input wire logic wr_valid_in,
	input wire logic [7:0] wr_data_in,
	input wire logic rd_req_in,
	input wire logic sample_valid_in,
	input wire logic [4:0] sample_chan_in,
	input wire logic [9:0] sample_data_in,
	input wire logic sample_error_in,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	output logic irq_out,
	output logic window_mode_out
);

	// ****************************************
	// elaboration checks
	// ****************************************
	if (CMD_WAIT_CYC < 1 || CMD_WAIT_CYC > 65535 || CHAN_GAP_CYC < 1 || CHAN_GAP_CYC > 65535) begin : g_bad_timing
		$error("host timing counts must lie in 1..65535");
	end
	if (CHAN_MASK == 21'h000000) begin : g_bad_mask
		$error("at least one channel must be populated");
	end

	localparam logic [15:0] CMD_WAIT = 16'(CMD_WAIT_CYC);
	localparam logic [15:0] CHAN_GAP = 16'(CHAN_GAP_CYC);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [ADCRD_NUM_SLOTS-1:0][ADCRD_RES_BITS-1:0] result;
		logic selected;
		logic [7:0] reg_sel;
		logic [1:0] byte_idx;
		logic [31:0] thresh;
		logic window_mode;
		logic window_irq_en;
		logic window_flag;
		logic error_flag;
		logic [15:0] since_cmd;
		logic [15:0] since_chan;
		logic [4:0] last_chan;
		logic [7:0] rd_data;
		logic rd_valid;
		logic irq;
	} adcrd_state_s;

	adcrd_state_s state_ff;
	adcrd_state_s nxt_state;

	logic is_result;
	logic [4:0] sel_chan;
	logic [ADCRD_RES_BITS-1:0] sel_val;
	logic [15:0] sel_word;
	logic [31:0] thresh_byte_shift;
	logic outside;
	logic [15:0] samp16;
	logic read_take;
	logic status_rd;
	logic en_clr_wr;

	// ****************************************
	// read decode
	// ****************************************
	always_comb begin
		is_result = state_ff.reg_sel >= ADCRD_REG_RESULT_FIRST
			&& state_ff.reg_sel <= ADCRD_REG_RESULT_LAST;
		sel_chan = 5'(state_ff.reg_sel - ADCRD_REG_RESULT_FIRST);
		sel_val = (is_result && CHAN_MASK[sel_chan]) ? state_ff.result[sel_chan] : 10'h000;
		sel_word = {6'h00, sel_val};
		samp16 = {6'h00, sample_data_in};
		// upper bound checked against the high half, lower against the low half
		outside = samp16 > state_ff.thresh[31:16] || samp16 < state_ff.thresh[15:0];
		thresh_byte_shift = {state_ff.thresh[23:0], wr_data_in};
		// qualified bus events, watched by the checks below
		read_take = state_ff.selected && rd_req_in && !cmd_valid_in && !wr_valid_in;
		status_rd = read_take && state_ff.reg_sel == ADCRD_REG_STATUS;
		en_clr_wr = state_ff.selected && wr_valid_in && !cmd_valid_in
			&& state_ff.reg_sel == ADCRD_REG_IRQ_ENABLE_CLEAR;
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_state.rd_valid = 1'b0;
		if (state_ff.since_cmd != 16'hFFFF) begin
			nxt_state.since_cmd = state_ff.since_cmd + 16'h0001;
		end
		if (state_ff.since_chan != 16'hFFFF) begin
			nxt_state.since_chan = state_ff.since_chan + 16'h0001;
		end

		if (cmd_valid_in) begin
			nxt_state.selected = cmd_base_in == ADCRD_MODULE_BASE;
			nxt_state.reg_sel = cmd_reg_in;
			nxt_state.byte_idx = 2'h0;
			nxt_state.since_cmd = 16'h0000;
		end else if (wr_valid_in && state_ff.selected) begin
			// saturates so a long burst never wraps back to byte 0
			if (state_ff.byte_idx != 2'h3) begin
				nxt_state.byte_idx = state_ff.byte_idx + 2'h1;
			end
			unique case (state_ff.reg_sel)
				ADCRD_REG_IRQ_ENABLE_SET: begin
					if (state_ff.byte_idx == 2'h0 && wr_data_in[ADCRD_IRQ_WINDOW_BIT]) begin
						nxt_state.window_irq_en = 1'b1;
					end
				end
				ADCRD_REG_IRQ_ENABLE_CLEAR: begin
					if (state_ff.byte_idx == 2'h0 && wr_data_in[ADCRD_IRQ_WINDOW_BIT]) begin
						nxt_state.window_irq_en = 1'b0;
					end
				end
				ADCRD_REG_WINDOW_MODE: begin
					if (state_ff.byte_idx == 2'h0) begin
						nxt_state.window_mode = wr_data_in == ADCRD_WINDOW_MODE_ON;
					end
				end
				ADCRD_REG_WINDOW_THRESH: begin
					// msb first; only the last four bytes written survive
					nxt_state.thresh = thresh_byte_shift;
				end
				default: begin
				end
			endcase
		end else if (rd_req_in && state_ff.selected) begin
			nxt_state.rd_valid = 1'b1;
			if (state_ff.byte_idx != 2'h3) begin
				nxt_state.byte_idx = state_ff.byte_idx + 2'h1;
			end
			if (state_ff.reg_sel == ADCRD_REG_STATUS) begin
				nxt_state.rd_data = 8'h00;
				nxt_state.rd_data[ADCRD_STATUS_ERROR_BIT] = state_ff.error_flag;
				nxt_state.rd_data[ADCRD_STATUS_WINDOW_BIT] = state_ff.window_flag;
				nxt_state.window_flag = 1'b0;
				nxt_state.error_flag = 1'b0;
			end else if (is_result) begin
				// big-endian: high byte first, padding bytes read zero
				unique case (state_ff.byte_idx)
					2'h0: nxt_state.rd_data = sel_word[15:8];
					2'h1: nxt_state.rd_data = sel_word[7:0];
					default: nxt_state.rd_data = 8'h00;
				endcase
				if (state_ff.byte_idx == 2'h0) begin
					// a premature read still answers but is reported
					if (state_ff.since_cmd < CMD_WAIT) begin
						nxt_state.error_flag = 1'b1;
					end
					if (sel_chan != state_ff.last_chan && state_ff.since_chan < CHAN_GAP) begin
						nxt_state.error_flag = 1'b1;
					end
					nxt_state.last_chan = sel_chan;
					nxt_state.since_chan = 16'h0000;
				end
			end else begin
				nxt_state.rd_data = 8'h00;
			end
		end

		if (sample_valid_in && 5'(sample_chan_in) <= 5'(ADCRD_MAX_CHAN)
			&& CHAN_MASK[sample_chan_in]) begin
			nxt_state.result[sample_chan_in] = sample_data_in;
			if (state_ff.window_mode && outside) begin
				nxt_state.window_flag = 1'b1;
			end
		end
		if (sample_error_in) begin
			nxt_state.error_flag = 1'b1;
		end

		nxt_state.irq = state_ff.window_flag && state_ff.window_irq_en;

		if (!rst_n_in) begin
			nxt_state.result = '0;
			nxt_state.selected = 1'b0;
			nxt_state.reg_sel = 8'h00;
			nxt_state.byte_idx = 2'h0;
			nxt_state.thresh = ADCRD_THRESH_RESET;
			nxt_state.window_mode = 1'b0;
			nxt_state.window_irq_en = 1'b0;
			nxt_state.window_flag = 1'b0;
			nxt_state.error_flag = 1'b0;
			nxt_state.since_cmd = 16'hFFFF;
			nxt_state.since_chan = 16'hFFFF;
			nxt_state.last_chan = 5'h00;
			nxt_state.rd_data = 8'h00;
			nxt_state.rd_valid = 1'b0;
			nxt_state.irq = 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		state_ff <= nxt_state;
	end

	assign rd_data_out = state_ff.rd_data;
	assign rd_valid_out = state_ff.rd_valid;
	assign irq_out = state_ff.irq;
	assign window_mode_out = state_ff.window_mode;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);

	// status register selected, then a read byte taken in that same cycle
	sequence s_select_status;
		state_ff.selected && state_ff.reg_sel == ADCRD_REG_STATUS;
	endsequence
	sequence s_first_read;
		rd_req_in && !cmd_valid_in && !wr_valid_in;
	endsequence

	a_base_select: assert property (
		!state_ff.selected && rd_req_in && !cmd_valid_in
		|=> !rd_valid_out)
		else $error("read answered while another module base was selected");

	a_result_value: assert property (
		state_ff.selected && is_result && state_ff.byte_idx == 2'h1 && rd_req_in
		&& !cmd_valid_in && !wr_valid_in
		|=> rd_valid_out && rd_data_out == $past(sel_word[7:0]))
		else $error("result low byte does not match the stored channel value");

	a_result_upper: assert property (
		state_ff.selected && is_result && state_ff.byte_idx == 2'h0 && rd_req_in
		&& !cmd_valid_in && !wr_valid_in
		|=> rd_data_out[7:2] == 6'h00)
		else $error("upper result bits are not zero");

	a_status_reserved: assert property (
		s_select_status ##0 s_first_read |=> rd_valid_out && rd_data_out[7:2] == 6'h00)
		else $error("status reserved bits are not zero");

	a_enable_set: assert property (
		state_ff.selected && state_ff.reg_sel == ADCRD_REG_IRQ_ENABLE_SET
		&& state_ff.byte_idx == 2'h0 && wr_valid_in && !cmd_valid_in && wr_data_in[0]
		|=> state_ff.window_irq_en)
		else $error("enable-set write did not enable the window interrupt");

	a_enable_clear: assert property (
		state_ff.selected && state_ff.reg_sel == ADCRD_REG_IRQ_ENABLE_CLEAR
		&& state_ff.byte_idx == 2'h0 && wr_valid_in && !cmd_valid_in && wr_data_in[0]
		|=> !state_ff.window_irq_en)
		else $error("enable-clear write did not disable the window interrupt");

	a_window_mode: assert property (
		state_ff.selected && state_ff.reg_sel == ADCRD_REG_WINDOW_MODE
		&& state_ff.byte_idx == 2'h0 && wr_valid_in && !cmd_valid_in
		|=> window_mode_out == ($past(wr_data_in) == ADCRD_WINDOW_MODE_ON))
		else $error("window mode does not follow the written value");

	a_irq_source: assert property (
		state_ff.window_flag && state_ff.window_irq_en |=> irq_out)
		else $error("enabled window flag did not raise the interrupt");

	a_irq_hold: assert property (
		irq_out && state_ff.window_flag && state_ff.window_irq_en && !status_rd && !en_clr_wr
		|=> ##1 irq_out)
		else $error("interrupt dropped without a status read");

	a_unpopulated_zero: assert property (
		rd_valid_out |-> $past(!is_result || CHAN_MASK[sel_chan] || !state_ff.selected)
		|| rd_data_out == 8'h00)
		else $error("unpopulated channel returned non-zero data");

	a_read_answer: assert property (
		read_take |=> rd_valid_out)
		else $error("accepted read byte was not answered");

	a_spurious_answer: assert property (
		!read_take |=> !rd_valid_out)
		else $error("read answer appeared without an accepted read");

	a_status_clear: assert property (
		status_rd && !sample_valid_in |=> !state_ff.window_flag)
		else $error("status read left the window flag set");

	a_irq_release: assert property (
		status_rd && !sample_valid_in |=> ##1 !irq_out)
		else $error("interrupt stayed high after a status read");

	a_irq_off: assert property (
		!state_ff.window_irq_en |=> !irq_out)
		else $error("interrupt raised with its source disabled");

	a_error_set: assert property (
		sample_error_in |=> state_ff.error_flag)
		else $error("converter error did not set the status error flag");

	a_early_read: assert property (
		read_take && is_result && state_ff.byte_idx == 2'h0 && state_ff.since_cmd < CMD_WAIT
		|=> state_ff.error_flag)
		else $error("premature result read was not reported");

	a_window_upper: assert property (
		state_ff.window_mode && sample_valid_in && sample_chan_in <= 5'(ADCRD_MAX_CHAN)
		&& CHAN_MASK[sample_chan_in] && {6'h00, sample_data_in} > state_ff.thresh[31:16]
		|=> state_ff.window_flag)
		else $error("sample above the upper threshold did not set the window flag");

	a_window_lower: assert property (
		state_ff.window_mode && sample_valid_in && sample_chan_in <= 5'(ADCRD_MAX_CHAN)
		&& CHAN_MASK[sample_chan_in] && {6'h00, sample_data_in} < state_ff.thresh[15:0]
		|=> state_ff.window_flag)
		else $error("sample below the lower threshold did not set the window flag");

	a_window_idle: assert property (
		!state_ff.window_mode && !state_ff.window_flag |=> !state_ff.window_flag)
		else $error("window flag set while window compare was off");

	a_thresh_shift: assert property (
		state_ff.selected && state_ff.reg_sel == ADCRD_REG_WINDOW_THRESH && wr_valid_in
		&& !cmd_valid_in |=> state_ff.thresh[7:0] == $past(wr_data_in))
		else $error("threshold byte was not shifted in at the low end");

	a_result_store: assert property (
		sample_valid_in && sample_chan_in == 5'h00 && CHAN_MASK[0]
		|=> state_ff.result[0] == $past(sample_data_in))
		else $error("channel 0 sample was not stored");

endmodule // adcrd_readout
